/* hdl/async_serial_rx_tx_core.v */
// How it works
// - Receiver samples input on a 16x tick and aligns to each start bit.
// - Start, data and stop bits sampled at ticks 8, 9, 10; majority wins.
// - Noise flag set when the three samples of any bit disagree.
// - Low idle line tested three more times; two zeros accept a start.
// - Accepted start with non-zero verification samples also sets noise.
// - Non-break framing error: continue as if stop seen, force ones history.
// - After a break framing error, wait for a real one before next start.
// - Transmit bit period is sixteen receive ticks.
// - Data register: transmit buffer on write, last received on read; no reset.
// - Ninth received bit loads with the data byte; no reset.
// - Ninth transmit bit loads into the shifter with the byte; no reset.
// - Character length bit: 1 selects nine bits, 0 eight; no reset.
// - Wake method bit: 1 address mark, 0 idle line; no reset.
// - Interrupt from each flag except noise and framing error, with its enable; reset clears the enables.
// - Enabling transmitter first sends ten or eleven ones; reset clears enable.
// - Receiver off stops receiver and its interrupts, flags kept.
// - Sleep bit puts receiver in standby; hardware clears it on wake.
// - Break bit sends groups of zeros, then one logic 1 when cleared.
// - Buffer empty flag sets on load to shifter, clears by read then write.
// - Complete flag sets when buffer empty and line quiet; read then write clears.
// - Receive flags clear by flag read with flag set, then data read.
// - On overrun the new character is dropped, buffer kept.
// - Framing error together with overrun sets only overrun.
`include "uart_core_defs.vh"

module async_serial_rx_tx_core (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire rx_sample_tick,
  input wire serial_in_pin,
  output reg serial_out_pin,
  output reg irq_n
);

  localparam RX_HUNT = 2'b00;
  localparam RX_VERIFY = 2'b01;
  localparam RX_BITS = 2'b10;

  function hit;
    input [7:0] addr;
    input [5:0] idx;
    begin
      hit = (addr[7:2] == idx) && (addr[1:0] == 2'b00);
    end
  endfunction

  function maj3;
    input a;
    input b;
    input c;
    begin
      maj3 = (a & b) | (a & c) | (b & c);
    end
  endfunction

  reg rx_meta_reg;
  reg rx_sync_reg;
  reg [7:0] rx_data_reg;
  reg rx_ninth_bit;
  reg [7:0] tx_data_reg;
  reg tx_ninth_bit;
  reg char9_reg;
  reg wake_addr_reg;
  reg [7:0] line_control_reg;
  reg [7:0] flags_reg;
  reg [7:0] arm_reg;
  reg [1:0] rx_state_reg;
  reg [4:0] rt_reg;
  reg [3:0] bit_idx_reg;
  reg [2:0] samp_reg;
  reg [1:0] vzero_reg;
  reg noise_acc_reg;
  reg allzero_reg;
  reg [8:0] rx_sh_reg;
  reg prev_high_reg;
  reg need_high_reg;
  reg [7:0] high_cnt_reg;
  reg rx_done_reg;
  reg rx_fe_reg;
  reg rx_nf_reg;
  reg idle_seen_reg;
  reg idle_arm_reg;
  reg [3:0] tx_div_reg;
  reg [10:0] tx_sh_reg;
  reg [3:0] tx_cnt_reg;
  reg tx_active_reg;
  reg pre_pend_reg;
  reg brk_was_reg;
  reg tx_load_reg;

  wire access = psel & penable & pready;
  wire wr = access & pwrite;
  wire rd = access & ~pwrite;
  wire hit_frame = hit(paddr, `IDX_FRAME);
  wire hit_line = hit(paddr, `IDX_LINE);
  wire hit_flags = hit(paddr, `IDX_FLAGS);
  wire hit_data = hit(paddr, `IDX_DATA);
  wire rx_on = line_control_reg[`LC_RXON];
  wire sleeping = line_control_reg[`LC_SLEEP];
  wire [3:0] frame_len = char9_reg ? `FRAME9 : `FRAME8;
  wire [3:0] stop_idx = char9_reg ? `STOP9 : `STOP8;
  wire [7:0] idle_len = char9_reg ? `IDLE9 : `IDLE8;
  wire tick = rx_sample_tick;
  wire bit_en = tick & (tx_div_reg == `TX_DIV_LAST);
  wire te_rise = wr & hit_line & pwdata[`LC_TXON] & ~line_control_reg[`LC_TXON];
  wire [7:0] got_data = char9_reg ? rx_sh_reg[7:0] : rx_sh_reg[8:1];
  wire got_mark = char9_reg ? rx_sh_reg[8] : rx_sh_reg[8];
  wire vote = maj3(samp_reg[0], samp_reg[1], rx_sync_reg);
  wire odd = ~((samp_reg[0] == samp_reg[1]) && (samp_reg[1] == rx_sync_reg));
  wire addr_wake = rx_done_reg & sleeping & wake_addr_reg & got_mark;
  wire idle_wake = idle_seen_reg & sleeping & ~wake_addr_reg;
  wire accept = rx_done_reg & (~sleeping | addr_wake);
  wire [7:0] rx_clr = (rd & hit_data) ? (arm_reg & `FL_RXMASK) : 8'h00;
  wire [7:0] tx_clr = (wr & hit_data) ? (arm_reg & `FL_TXMASK) : 8'h00;
  wire tx_buf_empty_flag_stays = flags_reg[`FL_TX_BUF_EMPTY_FLAG] & ~tx_clr[`FL_TX_BUF_EMPTY_FLAG];
  wire tc_set = tx_buf_empty_flag_stays & ~tx_active_reg & ~pre_pend_reg & ~brk_was_reg & ~line_control_reg[`LC_BRK];
  reg [7:0] flag_set;

  always @*
  begin
    flag_set = 8'h00;
    flag_set[`FL_TX_BUF_EMPTY_FLAG] = tx_load_reg;
    flag_set[`FL_TC] = tc_set;
    if (accept)
    begin
      if (flags_reg[`FL_RX_BUF_FULL_FLAG] & ~rx_clr[`FL_RX_BUF_FULL_FLAG])
        flag_set[`FL_OVR] = 1'b1;
      else
      begin
        flag_set[`FL_RX_BUF_FULL_FLAG] = 1'b1;
        flag_set[`FL_NF] = rx_nf_reg;
        flag_set[`FL_FE] = rx_fe_reg;
      end
    end
    flag_set[`FL_IDLE] = idle_seen_reg & ~sleeping;
  end

  // Input synchroniser; only the second stage is read.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
    end
    else
    begin
      rx_meta_reg <= serial_in_pin;
      rx_sync_reg <= rx_meta_reg;
    end
  end

  // Storage that reset leaves alone.
  always @(posedge pclk)
  begin
    if (wr & hit_data)
    begin
      tx_data_reg <= pwdata[7:0];
    end
    if (wr & hit_frame)
    begin
      tx_ninth_bit <= pwdata[`FC_TX9];
      char9_reg <= pwdata[`FC_CHAR9];
      wake_addr_reg <= pwdata[`FC_WAKE];
    end
    if (accept & ~(flags_reg[`FL_RX_BUF_FULL_FLAG] & ~rx_clr[`FL_RX_BUF_FULL_FLAG]))
    begin
      rx_data_reg <= got_data;
      rx_ninth_bit <= rx_sh_reg[8];
    end
  end

  // APB slave, control and flags; register answers with no wait state.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      line_control_reg <= `LC_RESET;
      flags_reg <= `FL_RESET;
      arm_reg <= 8'h00;
      irq_n <= 1'b1;
    end
    else
    begin
      pready <= psel & ~penable;
      if (psel & ~penable)
      begin
        pslverr <= ~(hit_frame | hit_line | hit_flags | hit_data);
        prdata <= 32'h0000_0000;
        if (hit_data)
          prdata[7:0] <= rx_data_reg;
        if (hit_frame)
          prdata[7:0] <= {rx_ninth_bit, tx_ninth_bit, 1'b0, char9_reg, wake_addr_reg, 3'b000};
        if (hit_line)
          prdata[7:0] <= line_control_reg;
        if (hit_flags)
          prdata[7:0] <= flags_reg;
      end
      else
      begin
        pslverr <= 1'b0;
      end
      if (wr & hit_line)
        line_control_reg <= pwdata[7:0];
      else if (addr_wake | idle_wake)
        line_control_reg[`LC_SLEEP] <= 1'b0;
      flags_reg <= (flags_reg & ~(rx_clr | tx_clr)) | flag_set;
      if (rd & hit_flags)
        arm_reg <= flags_reg;
      else if (access & hit_data)
        arm_reg <= arm_reg & ~(pwrite ? `FL_TXMASK : `FL_RXMASK);
      irq_n <= ~((flags_reg[`FL_TX_BUF_EMPTY_FLAG] & line_control_reg[`LC_TIE]) |
                 (flags_reg[`FL_TC] & line_control_reg[`LC_TX_DONE_IRQ_EN]) |
                 ((flags_reg[`FL_RX_BUF_FULL_FLAG] | flags_reg[`FL_OVR]) & line_control_reg[`LC_RIE] & rx_on) |
                 (flags_reg[`FL_IDLE] & line_control_reg[`LC_LINE_QUIET_IRQ_EN] & rx_on));
    end
  end

  // Receiver.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_state_reg <= RX_HUNT;
      rt_reg <= `RT_FIRST;
      bit_idx_reg <= 4'h0;
      samp_reg <= 3'b111;
      vzero_reg <= 2'b00;
      noise_acc_reg <= 1'b0;
      allzero_reg <= 1'b0;
      rx_sh_reg <= 9'h000;
      prev_high_reg <= 1'b0;
      need_high_reg <= 1'b1;
      high_cnt_reg <= 8'h00;
      rx_done_reg <= 1'b0;
      rx_fe_reg <= 1'b0;
      rx_nf_reg <= 1'b0;
      idle_seen_reg <= 1'b0;
      idle_arm_reg <= 1'b0;
    end
    else
    begin
      rx_done_reg <= 1'b0;
      idle_seen_reg <= 1'b0;
      if (!rx_on)
      begin
        rx_state_reg <= RX_HUNT;
        prev_high_reg <= 1'b0;
        high_cnt_reg <= 8'h00;
      end
      else if (tick)
      begin
        if (rx_sync_reg)
        begin
          need_high_reg <= 1'b0;
          if (high_cnt_reg != idle_len)
            high_cnt_reg <= high_cnt_reg + 8'h01;
          if (high_cnt_reg == idle_len - 8'h01 && (idle_arm_reg | sleeping))
          begin
            idle_seen_reg <= 1'b1;
            idle_arm_reg <= 1'b0;
          end
        end
        else
        begin
          high_cnt_reg <= 8'h00;
        end
        case (rx_state_reg)
          RX_HUNT:
          begin
            prev_high_reg <= rx_sync_reg & ~need_high_reg;
            if (prev_high_reg & ~rx_sync_reg & ~need_high_reg)
            begin
              rx_state_reg <= RX_VERIFY;
              rt_reg <= `RT_FIRST + 5'h01;
              vzero_reg <= 2'b00;
              noise_acc_reg <= 1'b0;
            end
          end
          RX_VERIFY:
          begin
            rt_reg <= rt_reg + 5'h01;
            if ((rt_reg == `RT_V1) || (rt_reg == `RT_V2))
            begin
              if (!rx_sync_reg)
                vzero_reg <= vzero_reg + 2'b01;
              else
                noise_acc_reg <= 1'b1;
            end
            if (rt_reg == `RT_V3)
            begin
              if (vzero_reg == 2'b10 || (vzero_reg == 2'b01 && !rx_sync_reg))
              begin
                rx_state_reg <= RX_BITS;
                bit_idx_reg <= 4'h0;
                allzero_reg <= 1'b1;
                if (rx_sync_reg)
                  noise_acc_reg <= 1'b1;
              end
              else
              begin
                rx_state_reg <= RX_HUNT;
                prev_high_reg <= rx_sync_reg;
              end
            end
          end
          RX_BITS:
          begin
            rt_reg <= (rt_reg == `RT_LAST) ? `RT_FIRST : rt_reg + 5'h01;
            if (rt_reg == `RT_LAST)
              bit_idx_reg <= bit_idx_reg + 4'h1;
            // A low stop bit outside a break waits out its bit period, so the artificial start falls where the next start is due.
            if (rt_reg == `RT_LAST && bit_idx_reg == `RX_PARK)
            begin
              rx_state_reg <= RX_HUNT;
              prev_high_reg <= 1'b1;
            end
            if ((rt_reg == `RT_S1) || (rt_reg == `RT_S2))
              samp_reg <= {samp_reg[1:0], rx_sync_reg};
            if (rt_reg == `RT_S3)
            begin
              if (odd)
                noise_acc_reg <= 1'b1;
              if (vote)
                allzero_reg <= 1'b0;
              if (bit_idx_reg == 4'h0 && vote)
              begin
                rx_state_reg <= RX_HUNT;
                prev_high_reg <= 1'b1;
              end
              else if (bit_idx_reg == stop_idx)
              begin
                rx_done_reg <= 1'b1;
                rx_fe_reg <= ~vote;
                rx_nf_reg <= noise_acc_reg | odd;
                idle_arm_reg <= 1'b1;
                if (!vote && allzero_reg)
                begin
                  rx_state_reg <= RX_HUNT;
                  need_high_reg <= 1'b1;
                  prev_high_reg <= 1'b0;
                end
                else if (!vote)
                begin
                  bit_idx_reg <= `RX_PARK;
                end
                else
                begin
                  rx_state_reg <= RX_HUNT;
                  prev_high_reg <= 1'b1;
                end
              end
              else if (bit_idx_reg != 4'h0)
              begin
                rx_sh_reg <= {vote, rx_sh_reg[8:1]};
              end
            end
          end
          default:
          begin
            rx_state_reg <= RX_HUNT;
          end
        endcase
      end
    end
  end

  // Transmitter; each bit lasts sixteen receive ticks.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_div_reg <= 4'h0;
      tx_sh_reg <= 11'h7ff;
      tx_cnt_reg <= 4'h0;
      tx_active_reg <= 1'b0;
      pre_pend_reg <= 1'b0;
      brk_was_reg <= 1'b0;
      tx_load_reg <= 1'b0;
      serial_out_pin <= 1'b1;
    end
    else
    begin
      tx_load_reg <= 1'b0;
      if (tick)
        tx_div_reg <= tx_div_reg + 4'h1;
      if (te_rise)
        pre_pend_reg <= 1'b1;
      if (bit_en)
      begin
        if (tx_cnt_reg != 4'h0)
        begin
          serial_out_pin <= tx_sh_reg[0];
          tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
          tx_cnt_reg <= tx_cnt_reg - 4'h1;
        end
        else if (pre_pend_reg & ~te_rise)
        begin
          serial_out_pin <= 1'b1;
          tx_sh_reg <= 11'h7ff;
          tx_cnt_reg <= frame_len - 4'h1;
          tx_active_reg <= 1'b1;
          pre_pend_reg <= 1'b0;
        end
        else if (line_control_reg[`LC_BRK])
        begin
          serial_out_pin <= 1'b0;
          tx_sh_reg <= 11'h000;
          tx_cnt_reg <= frame_len - 4'h1;
          tx_active_reg <= 1'b1;
          brk_was_reg <= 1'b1;
        end
        else if (brk_was_reg)
        begin
          serial_out_pin <= 1'b1;
          tx_sh_reg <= 11'h7ff;
          tx_active_reg <= 1'b1;
          brk_was_reg <= 1'b0;
        end
        else if (line_control_reg[`LC_TXON] & ~flags_reg[`FL_TX_BUF_EMPTY_FLAG])
        begin
          serial_out_pin <= 1'b0;
          tx_sh_reg <= char9_reg ? {2'b11, tx_ninth_bit, tx_data_reg} : {3'b111, tx_data_reg};
          tx_cnt_reg <= frame_len - 4'h1;
          tx_active_reg <= 1'b1;
          tx_load_reg <= 1'b1;
        end
        else
        begin
          serial_out_pin <= 1'b1;
          tx_active_reg <= 1'b0;
        end
      end
    end
  end

endmodule

/* hdl/uart_core_defs.vh */
`ifndef UART_CORE_DEFS_VH
`define UART_CORE_DEFS_VH

// Register indices; the byte address is four times the index.
`define IDX_FRAME 6'h0e
`define IDX_LINE 6'h0f
`define IDX_FLAGS 6'h10
`define IDX_DATA 6'h11

// Frame control fields.
`define FC_RX9 7
`define FC_TX9 6
`define FC_CHAR9 4
`define FC_WAKE 3

// Line control fields.
`define LC_TIE 7
`define LC_TX_DONE_IRQ_EN 6
`define LC_RIE 5
`define LC_LINE_QUIET_IRQ_EN 4
`define LC_TXON 3
`define LC_RXON 2
`define LC_SLEEP 1
`define LC_BRK 0
`define LC_RESET 8'h00

// Line flag fields.
`define FL_TX_BUF_EMPTY_FLAG 7
`define FL_TC 6
`define FL_RX_BUF_FULL_FLAG 5
`define FL_IDLE 4
`define FL_OVR 3
`define FL_NF 2
`define FL_FE 1
`define FL_RESET 8'hc0
`define FL_RXMASK 8'h3e
`define FL_TXMASK 8'hc0

// Receive tick positions within one bit period.
`define RT_FIRST 5'h01
`define RT_LAST 5'h10
`define RT_V1 5'h03
`define RT_V2 5'h05
`define RT_V3 5'h07
`define RT_S1 5'h08
`define RT_S2 5'h09
`define RT_S3 5'h0a
`define TX_DIV_LAST 4'hf

// Frame lengths in bits and idle lengths in receive ticks.
`define FRAME8 4'ha
`define FRAME9 4'hb
`define STOP8 4'h9
`define STOP9 4'ha
`define RX_PARK 4'hf
`define IDLE8 8'ha0
`define IDLE9 8'hb0

`endif

/* verification/uart_props.sv */
`include "uart_core_defs.vh"
module uart_props (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire rx_sample_tick,
  input wire serial_in_pin,
  input wire serial_out_pin,
  input wire irq_n
);
  timeunit 1ns;
  timeprecision 1ns;
  wire acc = psel && penable && pready;
  wire lcw = acc && pwrite && paddr == {`IDX_LINE, 2'b00};
  wire map_ok = paddr[1:0] == 2'b00 && paddr[7:2] >= `IDX_FRAME && paddr[7:2] <= `IDX_DATA;
  reg [7:0] lc_reg;
  reg [3:0] tk_reg;
  reg [8:0] pre_reg;
  reg prev_reg;
  reg seen_reg;
  reg arm_reg;
  reg ever_reg;
  wire [3:0] en = {lc_reg[7:6], lc_reg[5] & lc_reg[2], lc_reg[4] & lc_reg[2]};
  // Shadows line control and counts receive ticks between output edges.
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      lc_reg <= 8'h00;
      tk_reg <= 4'h0;
      pre_reg <= 9'h000;
      prev_reg <= 1'b1;
      seen_reg <= 1'b0;
      arm_reg <= 1'b0;
      ever_reg <= 1'b0;
    end
    else
    begin
      prev_reg <= serial_out_pin;
      if (lcw)
        lc_reg <= pwdata[7:0];
      if (lcw && pwdata[`LC_TXON])
        ever_reg <= 1'b1;
      if (serial_out_pin != prev_reg)
      begin
        seen_reg <= 1'b1;
        tk_reg <= 4'h0;
      end
      else if (rx_sample_tick)
        tk_reg <= tk_reg + 4'h1;
      if (lcw && pwdata[`LC_TXON] && !pwdata[`LC_BRK] && !lc_reg[`LC_TXON])
      begin
        arm_reg <= 1'b1;
        pre_reg <= 9'h000;
      end
      else if (!serial_out_pin)
        arm_reg <= 1'b0;
      else if (arm_reg && rx_sample_tick && pre_reg != 9'h1ff)
        pre_reg <= pre_reg + 9'h001;
    end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_ready;
    psel && !penable |=> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_err;
    psel && !penable |=> pslverr == !$past(map_ok);
  endproperty
  a_err: assert property (p_err) else $error("wrong slave error");
  property p_bit;
    seen_reg && serial_out_pin != prev_reg |-> tk_reg == 4'h0;
  endproperty
  a_bit: assert property (p_bit) else $error("tx edge off bit grid");
  property p_idle;
    !ever_reg |-> serial_out_pin;
  endproperty
  a_idle: assert property (p_idle) else $error("line not idle high");
  property p_pre;
    arm_reg && $fell(serial_out_pin) |-> pre_reg >= 9'h0a0;
  endproperty
  a_pre: assert property (p_pre) else $error("preamble too short");
  property p_brk;
    lc_reg[0] && $past(lc_reg[0]) && !$past(serial_out_pin) |-> !serial_out_pin;
  endproperty
  a_brk: assert property (p_brk) else $error("break not continuous");
  property p_en;
    en == 4'h0 && $past(en) == 4'h0 |-> irq_n;
  endproperty
  a_en: assert property (p_en) else $error("irq without enable");
  property p_lvl;
    !irq_n && !acc && !$past(acc) && !lc_reg[6] |=> !irq_n;
  endproperty
  a_lvl: assert property (p_lvl) else $error("irq dropped alone");
endmodule

bind async_serial_rx_tx_core uart_props u_props (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .rx_sample_tick(rx_sample_tick),
  .serial_in_pin(serial_in_pin),
  .serial_out_pin(serial_out_pin),
  .irq_n(irq_n)
);

/* verification/remote_node.sv */
module remote_node (
  input wire pclk,
  input wire rx_sample_tick,
  input wire serial_out_pin,
  output logic serial_in_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial serial_in_pin = 1'b1;
  task automatic ticks(input int n);
    repeat (n) @(posedge pclk iff rx_sample_tick);
  endtask
  // Sends one frame; tick gt of bit gb is inverted to model noise.
  task automatic send(input logic [8:0] ch, input int nb, input logic stp, input int gb, input int gt);
    logic [10:0] fr;
    fr = {1'b1, ch, 1'b0};
    fr[nb + 1] = stp;
    ticks(1);
    for (int b = 0; b < nb + 2; b++)
      for (int t = 1; t <= 16; t++)
      begin
        serial_in_pin <= fr[b] ^ (b == gb && t == gt);
        ticks(1);
      end
    serial_in_pin <= 1'b1;
  endtask
  // Captures data bits and the stop bit at mid-bit, least significant first.
  task automatic recv(input int nb, output logic [9:0] ch);
    ch = 10'h000;
    @(negedge serial_out_pin);
    ticks(8);
    for (int b = 0; b <= nb; b++)
    begin
      ticks(16);
      ch[b] = serial_out_pin;
    end
  endtask
endmodule

/* verification/tb.sv */
`include "uart_core_defs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic rx_sample_tick = 1'b0;
  logic [1:0] tdiv = 2'b00;
  wire [31:0] prdata;
  wire pready, pslverr, serial_in_pin, serial_out_pin, irq_n;
  int failures = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [7:0] rd;
  logic err;
  logic [9:0] got;
  logic [8:0] tch [6] = '{9'h0a5, 9'h03c, 9'h05a, 9'h081, 9'h000, 9'h06b};
  logic tst [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
  int tgb [6] = '{99, 3, 0, 99, 99, 99};
  int tgt [6] = '{0, 9, 5, 0, 0, 0};
  logic [7:0] tfl [6] = '{8'he0, 8'he4, 8'he4, 8'he2, 8'he2, 8'he0};
  async_serial_rx_tx_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_sample_tick(rx_sample_tick), .serial_in_pin(serial_in_pin),
    .serial_out_pin(serial_out_pin), .irq_n(irq_n));
  remote_node peer (.pclk(pclk), .rx_sample_tick(rx_sample_tick), .serial_out_pin(serial_out_pin),
    .serial_in_pin(serial_in_pin));
  always #5 pclk = ~pclk;
  // The sample tick runs at a quarter of the bus clock to keep frames short.
  always @(posedge pclk)
  begin
    tdiv <= tdiv + 2'b01;
    rx_sample_tick <= tdiv == 2'b11;
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      failures++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] seen);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [5:0] idx, input logic [7:0] exp, input string nm);
    bus(1'b0, idx, 8'h00);
    chk(nm, exp, rd);
  endtask
  task automatic poll(input logic [7:0] m);
    do
      bus(1'b0, `IDX_FLAGS, 8'h00);
    while ((rd & m) == 8'h00);
  endtask
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`IDX_LINE, 8'h00, "line reset");
    rdc(`IDX_FLAGS, 8'hc0, "flags reset");
    chk("irq reset", 1'b1, irq_n);
    bus(1'b0, 6'h20, 8'h00);
    chk("unmapped err", 1'b1, err);
    chk("unmapped data", 8'h00, rd);
    bus(1'b1, `IDX_FRAME, 8'h58);
    bus(1'b0, `IDX_FRAME, 8'h00);
    chk("frame rw", 8'h58, rd & 8'h7f);
    bus(1'b1, `IDX_FRAME, 8'h00);
    bus(1'b1, `IDX_LINE, 8'h24);
    // The receiver must see the idle line high before the first start bit.
    peer.ticks(2);
    for (int i = 0; i < 6; i++)
    begin
      peer.send(tch[i], 8, tst[i], tgb[i], tgt[i]);
      poll(8'h20);
      chk("rx flags", tfl[i], rd);
      chk("rx irq", 1'b0, irq_n);
      rdc(`IDX_DATA, tch[i][7:0], "rx data");
      rdc(`IDX_FLAGS, 8'hc0, "rx cleared");
    end
    peer.send(9'h011, 8, 1'b1, 99, 0);
    peer.send(9'h022, 8, 1'b0, 99, 0);
    rdc(`IDX_FLAGS, 8'he8, "overrun flags");
    rdc(`IDX_DATA, 8'h11, "overrun data");
    peer.send(9'h044, 8, 1'b1, 99, 0);
    bus(1'b1, `IDX_LINE, 8'h20);
    peer.send(9'h055, 8, 1'b1, 99, 0);
    chk("rx off irq", 1'b1, irq_n);
    rdc(`IDX_FLAGS, 8'he0, "rx off flags");
    rdc(`IDX_DATA, 8'h44, "rx off data");
    bus(1'b1, `IDX_LINE, 8'h04);
    bus(1'b1, `IDX_FRAME, 8'h10);
    peer.send(9'h1c6, 9, 1'b1, 99, 0);
    rdc(`IDX_FRAME, 8'h90, "ninth bit");
    rdc(`IDX_DATA, 8'hc6, "nine data");
    bus(1'b0, `IDX_FLAGS, 8'h00);
    bus(1'b0, `IDX_DATA, 8'h00);
    bus(1'b1, `IDX_FRAME, 8'h08);
    bus(1'b1, `IDX_LINE, 8'h06);
    peer.send(9'h023, 8, 1'b1, 99, 0);
    rdc(`IDX_LINE, 8'h06, "still asleep");
    rdc(`IDX_FLAGS, 8'hc0, "asleep flags");
    peer.send(9'h0a4, 8, 1'b1, 99, 0);
    rdc(`IDX_LINE, 8'h04, "woken");
    rdc(`IDX_DATA, 8'ha4, "wake data");
    peer.ticks(170);
    rdc(`IDX_FLAGS, 8'hf0, "idle flag");
    bus(1'b1, `IDX_FRAME, 8'h00);
    bus(1'b0, `IDX_FLAGS, 8'h00);
    bus(1'b1, `IDX_DATA, 8'h5a);
    bus(1'b0, `IDX_FLAGS, 8'h00);
    chk("tx pending", 8'h00, rd & `FL_TXMASK);
    bus(1'b1, `IDX_LINE, 8'h88);
    peer.recv(8, got);
    chk("tx frame", 10'h15a, got);
    chk("tx irq", 1'b0, irq_n);
    bus(1'b1, `IDX_FRAME, 8'h50);
    bus(1'b0, `IDX_FLAGS, 8'h00);
    bus(1'b1, `IDX_DATA, 8'h3c);
    peer.recv(9, got);
    chk("tx nine", 10'h33c, got);
    poll(8'h40);
    chk("tx done", 8'hc0, rd & `FL_TXMASK);
    bus(1'b1, `IDX_LINE, 8'h09);
    peer.ticks(40);
    chk("break low", 1'b0, serial_out_pin);
    peer.ticks(200);
    chk("break held", 1'b0, serial_out_pin);
    bus(1'b1, `IDX_LINE, 8'h08);
    peer.ticks(200);
    chk("break end", 1'b1, serial_out_pin);
    close_out();
  end
endmodule
